// ===== host_port_pkg.sv
// shared constants for the host bus port
package host_port_pkg;
  localparam int DATA_WIDTH = 18;
  localparam int FIFO_DEPTH = 4;
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int REF_CYCLE_TIME_NS = 9;
  localparam int FIRST_READ_DELAY_CYC = 5;
  localparam int SELECT_LOW_WIDTH_CYC = 1;
  localparam int SELECT_HIGH_WIDTH_CYC = 1;
  localparam logic [2:0] READ_DELAY_LOAD = 3'h4;
  localparam logic [17:0] READ_RESET_VALUE = 18'h00000;
  localparam logic INTEL_STYLE_MODE = 1'b0;
  localparam logic MOTOROLA_STYLE_MODE = 1'b1;
endpackage

// ===== port_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module port_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 4
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign o_in_ready = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_clock)
  begin
    if (push)
    begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // port_fifo
`default_nettype wire

// ===== lcd_host_port.sv
// parallel host bus port of the display controller
`timescale 1ns/1ps
`default_nettype none
module lcd_host_port
  import host_port_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_motorola_style_mode,
  input wire logic i_chip_select_n,
  input wire logic i_reg_data_select,
  input wire logic i_write_strobe,
  input wire logic i_read_strobe,
  input wire logic [DATA_WIDTH-1:0] i_host_data_bus,
  output logic [DATA_WIDTH-1:0] o_host_data_bus,
  output logic o_host_data_bus_oe_n,
  output logic o_word_valid,
  input wire logic i_word_ready,
  output logic o_word_is_command,
  output logic [DATA_WIDTH-1:0] o_word_data,
  output logic o_write_stall,
  input wire logic [DATA_WIDTH-1:0] i_read_data
);
  typedef enum logic [1:0] {
    IDLE = 2'b00,
    ACTIVE = 2'b01,
    GAP = 2'b11
  } bus_state_t;

  bus_state_t state;
  logic select_prev;
  logic e_prev;
  logic active;
  logic is_read;
  logic strobe_edge;
  logic write_take;
  logic reading;
  logic [2:0] read_delay;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [DATA_WIDTH:0] fifo_out_data;
  logic [DATA_WIDTH:0] write_word;
  logic write_valid;
  logic out_valid;
  logic out_fire;

  // intel by default; the mode pin is high only for motorola
  always_comb
  begin
    if (i_motorola_style_mode == MOTOROLA_STYLE_MODE)
    begin
      active = !i_chip_select_n && i_write_strobe;
      is_read = i_read_strobe;
      // end of access on E rise or select rise, whichever strobes
      strobe_edge = (!e_prev && i_write_strobe && !i_chip_select_n) ||
                    (!select_prev && i_chip_select_n && i_write_strobe);
      write_take = strobe_edge && !is_read;
    end
    else
    begin
      active = !i_chip_select_n;
      is_read = !i_read_strobe;
      strobe_edge = !i_write_strobe && e_prev && !i_chip_select_n;
      write_take = strobe_edge;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      select_prev <= 1'b1;
      e_prev <= 1'b1;
    end
    else
    begin
      select_prev <= i_chip_select_n;
      e_prev <= i_write_strobe;
    end
  end

  // access framing: select low, then high gap
  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      state <= IDLE;
    end
    else
    begin
      case (state)
        IDLE: if (!i_chip_select_n) state <= ACTIVE;
        ACTIVE: if (i_chip_select_n) state <= GAP;
        GAP: state <= i_chip_select_n ? IDLE : ACTIVE;
        default: state <= IDLE;
      endcase
    end
  end

  // write capture into fifo, command flag carried in top bit
  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      write_valid <= 1'b0;
      write_word <= '0;
    end
    else
    begin
      if (write_valid && fifo_in_ready)
      begin
        write_valid <= 1'b0;
      end
      // a new take wins over the clear of the slot it reuses
      if (write_take && (!write_valid || fifo_in_ready))
      begin
        write_valid <= 1'b1;
        write_word <= {!i_reg_data_select, i_host_data_bus};
      end
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      o_write_stall <= 1'b0;
    end
    else
    begin
      o_write_stall <= write_valid && !fifo_in_ready;
    end
  end

  port_fifo #(
    .WIDTH(DATA_WIDTH + 1),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_in_valid(write_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data(write_word),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(!out_valid || i_word_ready),
    .o_out_data(fifo_out_data)
  );

  // registered output stage toward the controller core
  assign out_fire = fifo_out_valid && (!out_valid || i_word_ready);

  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      out_valid <= 1'b0;
      o_word_is_command <= 1'b0;
      o_word_data <= '0;
    end
    else
    begin
      if (out_fire)
      begin
        out_valid <= 1'b1;
        o_word_is_command <= fifo_out_data[DATA_WIDTH];
        o_word_data <= fifo_out_data[DATA_WIDTH-1:0];
      end
      else if (i_word_ready)
      begin
        out_valid <= 1'b0;
      end
    end
  end

  assign o_word_valid = out_valid;

  // read path: bus driven only during active read, data after delay
  assign reading = active && is_read;

  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      read_delay <= READ_DELAY_LOAD;
      o_host_data_bus <= READ_RESET_VALUE;
      o_host_data_bus_oe_n <= 1'b1;
    end
    else if (reading)
    begin
      o_host_data_bus_oe_n <= 1'b0;
      if (read_delay != 3'h0)
      begin
        read_delay <= read_delay - 3'h1;
      end
      else
      begin
        o_host_data_bus <= i_read_data;
      end
    end
    else
    begin
      read_delay <= READ_DELAY_LOAD;
      o_host_data_bus_oe_n <= 1'b1;
    end
  end
endmodule // lcd_host_port
`default_nettype wire

// ===== port_checker.sv
// pin checker for the host port
`timescale 1ns/1ps
`default_nettype none
module port_checker
  import host_port_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_motorola_style_mode,
  input wire logic i_chip_select_n,
  input wire logic i_write_strobe,
  input wire logic i_read_strobe,
  input wire logic o_host_data_bus_oe_n,
  input wire logic o_word_valid,
  input wire logic i_word_ready,
  input wire logic [DATA_WIDTH-1:0] o_word_data,
  input wire logic o_write_stall
);
  wire logic m = i_motorola_style_mode;
  wire logic cs = !i_chip_select_n;
  wire logic oe = o_host_data_bus_oe_n;
  wire logic v = o_word_valid;
  wire logic rd = i_read_strobe;
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (!i_resetn);
  sequence s_take;
    cs && (m ? $rose(i_write_strobe) && !rd : $fell(i_write_strobe));
  endsequence
  property p_rst;
    disable iff (1'b0) !i_resetn |=> !v && oe && !o_write_stall;
  endproperty
  a_rst: assert property (p_rst) else $error("reset");
  property p_hold; v && !i_word_ready |=> v && $stable(o_word_data); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_i80; !m ##0 s_take |-> ##[1:3] v; endproperty
  a_i80: assert property (p_i80) else $error("i80 write");
  property p_m68; m ##0 s_take |-> ##[1:3] v; endproperty
  a_m68: assert property (p_m68) else $error("m68 write");
  property p_idle; (!cs)[*5] ##0 !v |=> !v; endproperty
  a_idle: assert property (p_idle) else $error("idle word");
  property p_rd_on; !m && cs && $fell(rd) |=> !oe; endproperty
  a_rd_on: assert property (p_rd_on) else $error("read drive");
  property p_rd_off; !m && $rose(rd) |-> ##[1:2] oe; endproperty
  a_rd_off: assert property (p_rd_off) else $error("release");
  property p_rd_idle; (!m && rd)[*3] |-> oe; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("idle drive");
endmodule // port_checker
bind lcd_host_port port_checker port_checker_i (.*);
`default_nettype wire

// ===== host_model.sv
// host model driving the bus strobes
`timescale 1ns/1ps
`default_nettype none
module host_model
  import host_port_pkg::*;
(
  input wire logic i_clock,
  output logic o_mode,
  output logic o_cs_n,
  output logic o_rs,
  output logic o_wr,
  output logic o_rd,
  output logic o_touch_select_n,
  output logic [DATA_WIDTH-1:0] o_d
);
  initial
  begin
    {o_mode, o_d} = '0;
    {o_cs_n, o_rs, o_wr, o_rd} = 4'hF;
    // touch chip stays deselected, no serial traffic here
    o_touch_select_n = 1'b1;
  end
  // k: in motorola mode select strobes while E is parked high
  task automatic put(input logic m, c, s, k,
    input logic [DATA_WIDTH-1:0] d);
    @(posedge i_clock);
    o_mode <= m;
    o_wr <= !m || k;
    @(posedge i_clock);
    o_rs <= !c;
    o_d <= d;
    o_rd <= !m;
    o_cs_n <= s;
    o_wr <= m && k;
    @(posedge i_clock);
    o_wr <= 1'b1;
    @(posedge i_clock);
    o_wr <= !m || k;
    @(posedge i_clock);
    o_cs_n <= 1'b1;
    @(posedge i_clock);
    o_rd <= 1'b1;
    o_d <= ~d;
  endtask
  task automatic get(input logic m, input int n, input logic last);
    @(posedge i_clock);
    o_mode <= m;
    o_wr <= 1'b1;
    o_rd <= m;
    o_cs_n <= 1'b0;
    repeat (n) @(posedge i_clock);
    if (last)
      {o_cs_n, o_rd} <= 2'h3;
  endtask
endmodule // host_model
`default_nettype wire

// ===== testbench.sv
// self-checking bench for the host bus port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import host_port_pkg::*;
  logic i_clock = 0;
  logic i_resetn = 0;
  logic i_word_ready = 0;
  logic mode, cs_n, rs, wr, rd, oe_n, valid, cmd;
  logic [DATA_WIDTH-1:0] hd, bus, dq, wd, rdat = '0;
  logic [DATA_WIDTH:0] exp_q[$];
  int err_count = 0;
  int cmp_count = 0;
  assign bus = oe_n ? hd : dq;
  initial forever #5 i_clock = ~i_clock;
  host_model host_model_i (.i_clock, .o_mode(mode), .o_cs_n(cs_n),
    .o_rs(rs), .o_wr(wr), .o_rd(rd), .o_touch_select_n(), .o_d(hd));
  lcd_host_port lcd_host_port_i (.i_clock, .i_resetn,
    .i_motorola_style_mode(mode), .i_chip_select_n(cs_n),
    .i_reg_data_select(rs), .i_write_strobe(wr), .i_read_strobe(rd),
    .i_host_data_bus(bus), .o_host_data_bus(dq),
    .o_host_data_bus_oe_n(oe_n), .o_word_valid(valid), .i_word_ready,
    .o_word_is_command(cmd), .o_word_data(wd), .o_write_stall(),
    .i_read_data(rdat));
  task automatic chk(input logic [DATA_WIDTH:0] s, e);
    cmp_count++;
    if (s !== e)
    begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge i_clock)
  begin
    if (valid && i_word_ready)
      chk({cmd, wd}, exp_q.pop_front());
    i_word_ready <= ($urandom % 4) != 0;
  end
  initial
  begin
    logic [DATA_WIDTH-1:0] d, r;
    logic c, s;
    void'($urandom(72));
    repeat (12) @(posedge i_clock);
    i_resetn <= 1'b1;
    for (int i = 0; i < 24; i++)
    begin
      d = DATA_WIDTH'($urandom);
      c = 1'($urandom);
      s = i % 6 == 5;
      if (!s)
        exp_q.push_back({c, d});
      host_model_i.put(i >= 16, c, s, i % 2 == 1, d);
    end
    for (int k = 0; k < 40 && exp_q.size() > 0; k++)
      @(posedge i_clock);
    chk(exp_q.size(), 0);
    $display("write test done");
    d = READ_RESET_VALUE;
    for (int m = 0; m < 2; m++)
    begin
      r = DATA_WIDTH'($urandom);
      @(posedge i_clock);
      rdat <= r;
      host_model_i.get(1'(m), 4, 1'b0);
      #1;
      chk(dq, d);
      host_model_i.get(1'(m), 4, 1'b1);
      #1;
      chk({oe_n, dq}, {1'b0, r});
      @(posedge i_clock);
      #1;
      chk(oe_n, 1'b1);
      d = r;
    end
    $display("read test done");
    @(posedge i_clock);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clock);
    #1;
    chk({valid, oe_n}, 2'h1);
    @(posedge i_clock);
    i_resetn <= 1'b1;
    d = DATA_WIDTH'($urandom);
    exp_q.push_back({1'b1, d});
    host_model_i.put(1'b0, 1'b1, 1'b0, 1'b0, d);
    for (int k = 0; k < 40 && exp_q.size() > 0; k++)
      @(posedge i_clock);
    chk(exp_q.size(), 0);
    $display("reset test done");
    finish_test();
  end
  initial
  begin
    #20us;
    err_count++;
    finish_test();
  end
endmodule // testbench
`default_nettype wire
